// ### core/cem_pkg.sv
// constants for the charger event interrupt mask bank
// assumes a byte-wide register port and one-cycle event pulses
`default_nettype none
package cem_pkg;
  // register offsets
  localparam logic [7:0] OFFS_CHG_MASK_TWO   = 8'h2A;
  localparam logic [7:0] OFFS_CHG_MASK_THREE = 8'h2B;
  localparam logic [7:0] OFFS_FLT_MASK_ZERO  = 8'h2C;
  localparam logic [7:0] OFFS_FLT_MASK_ONE   = 8'h2D;
  localparam int         NUM_REGS            = 4;

  // value after reset of every mask register
  localparam logic [7:0] MASK_RESET_VAL = 8'h00;
  // answer to a read of an unmapped offset
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  // writable bits per register, index 0 is offset 0x2a
  localparam logic [NUM_REGS-1:0][7:0] WR_BITS = {8'hFC, 8'hFF, 8'h1F, 8'h7F};
  // bits whose events reach the interrupt (reserved bits carry no event)
  localparam logic [NUM_REGS-1:0][7:0] EVT_BITS = {8'hF4, 8'hFF, 8'h1F, 8'h7F};
  // registers also cleared on watchdog expiry
  localparam logic [NUM_REGS-1:0]      WD_CLEARS = 4'h2;

  // field positions, charger mask two
  localparam int DATALINE_DETECT_DONE_BIT = 6;
  localparam int CONV_DONE_BIT            = 5;
  localparam int MIN_SYSTEM_REG_BIT       = 4;
  localparam int FAST_CHARGE_TIMER_BIT    = 3;
  localparam int TRICKLE_TIMER_BIT        = 2;
  localparam int PRECHARGE_TIMER_BIT      = 1;
  localparam int TOPOFF_TIMER_BIT         = 0;
  // charger mask three
  localparam int BATTERY_LOW_FOR_OTG_BIT  = 4;
  localparam int THERMISTOR_COLD_BIT      = 3;
  localparam int THERMISTOR_COOL_BIT      = 2;
  localparam int THERMISTOR_WARM_BIT      = 1;
  localparam int THERMISTOR_HOT_BIT       = 0;
  // fault mask zero
  localparam int BATTERY_CURRENT_REG_BIT  = 7;
  localparam int INPUT_BUS_OVERVOLT_BIT   = 6;
  localparam int BATTERY_OVERVOLT_BIT     = 5;
  localparam int INPUT_OVERCURRENT_BIT    = 4;
  localparam int BATTERY_OVERCURRENT_BIT  = 3;
  localparam int CONVERTER_OVERCURR_BIT   = 2;
  localparam int SECOND_INPUT_OVP_BIT     = 1;
  localparam int FIRST_INPUT_OVP_BIT      = 0;
  // fault mask one
  localparam int SYSTEM_SHORT_BIT         = 7;
  localparam int SYSTEM_OVERVOLT_BIT      = 6;
  localparam int OTG_OUTPUT_OVERVOLT_BIT  = 5;
  localparam int OTG_OUTPUT_UNDERVOLT_BIT = 4;
  localparam int THERMAL_SHUTDOWN_BIT     = 2;
endpackage : cem_pkg
`default_nettype wire

// ### core/cem_mask_reg.sv
// one byte-wide mask register with selectable writable bits
// assumes write, reset command and watchdog strobes are one-cycle pulses
`default_nettype none
module cem_mask_reg #(
  parameter logic [7:0] WR_BITS  = 8'hFF,
  parameter bit         WD_CLEAR = 1'b0
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // control
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_reg_reset,
  input  wire logic       i_watchdog,
  // mask value
  output logic      [7:0] o_mask
);
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic       clear_now;

  // reset command beats a write in the same cycle
  assign clear_now = i_reg_reset | (WD_CLEAR & i_watchdog);
  assign mask_nxt  = clear_now ? cem_pkg::MASK_RESET_VAL
                   : i_wr_en   ? (i_wdata & WR_BITS)
                   : mask_r;

  // register, reserved bits never leave zero
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_r <= cem_pkg::MASK_RESET_VAL;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  assign o_mask = mask_r;
endmodule : cem_mask_reg
`default_nettype wire

// ### core/cem_interrupt_masks.sv
// charger event interrupt mask bank: four mask registers gating event
// pulses onto a one-cycle interrupt pulse
// assumes event inputs are one-cycle pulses synchronous to i_sys_clk and
// that the serial register front end presents byte reads and writes
`default_nettype none
module cem_interrupt_masks (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // register port
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_rvalid,
  // reset sources
  input  wire logic       i_reg_reset_cmd,
  input  wire logic       i_watchdog_expire,
  // converter mode
  input  wire logic       i_conv_single_shot,
  // event pulses, bit layout equals the mask register layout
  input  wire logic [7:0] i_charger_events_two,
  input  wire logic [7:0] i_charger_events_three,
  input  wire logic [7:0] i_fault_events_zero,
  input  wire logic [7:0] i_fault_events_one,
  // event pulses passed on unmasked, for the flag logic
  output logic [7:0]      o_charger_flags_two,
  output logic [7:0]      o_charger_flags_three,
  output logic [7:0]      o_fault_flags_zero,
  output logic [7:0]      o_fault_flags_one,
  // interrupt to the host
  output logic            o_int_pulse
);
  localparam int NR = cem_pkg::NUM_REGS;

  // offset decode, also used for the read mux
  function automatic logic [NR-1:0] decode_offset(input logic [7:0] addr);
    logic [NR-1:0] sel;
    sel = '0;
    sel[0] = (addr == cem_pkg::OFFS_CHG_MASK_TWO);
    sel[1] = (addr == cem_pkg::OFFS_CHG_MASK_THREE);
    sel[2] = (addr == cem_pkg::OFFS_FLT_MASK_ZERO);
    sel[3] = (addr == cem_pkg::OFFS_FLT_MASK_ONE);
    return sel;
  endfunction : decode_offset

  logic [NR-1:0]      wr_sel;
  logic [NR-1:0]      rd_sel;
  logic [NR-1:0][7:0] mask_val;
  logic [NR-1:0][7:0] events;
  logic [NR-1:0][7:0] passed;
  logic [NR-1:0][7:0] rd_terms;
  logic [7:0]         rd_data;
  logic               any_passed;
  logic [7:0]         rdata_r;
  logic               rvalid_r;
  logic               int_r;
  logic [NR-1:0][7:0] flags_r;

  // select decode
  assign wr_sel = i_reg_wr ? decode_offset(i_reg_addr) : '0;
  assign rd_sel = decode_offset(i_reg_addr);

  // conversion done only counts while the converter runs single-shot
  assign events[0] = i_charger_events_two &
                     ~(8'h01 << cem_pkg::CONV_DONE_BIT) |
                     ({7'h00, i_conv_single_shot & i_charger_events_two[cem_pkg::CONV_DONE_BIT]}
                      << cem_pkg::CONV_DONE_BIT);
  assign events[1] = i_charger_events_three;
  assign events[2] = i_fault_events_zero;
  assign events[3] = i_fault_events_one;

  // one register and one gate row per mask byte
  genvar gi;
  generate
    for (gi = 0; gi < NR; gi++) begin : g_bank
      cem_mask_reg #(
        .WR_BITS  (cem_pkg::WR_BITS[gi]),
        .WD_CLEAR (cem_pkg::WD_CLEARS[gi])
      ) u_mask (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_wr_en     (wr_sel[gi]),
        .i_wdata     (i_reg_wdata),
        .i_reg_reset (i_reg_reset_cmd),
        .i_watchdog  (i_watchdog_expire),
        .o_mask      (mask_val[gi])
      );
      assign rd_terms[gi] = rd_sel[gi] ? mask_val[gi] : 8'h00;
    end
  endgenerate

  // named mask fields, charger mask two
  logic dataline_detect_done_mask;
  logic conv_done_mask;
  logic min_system_reg_mask;
  logic fast_charge_timer_mask;
  logic trickle_timer_mask;
  logic precharge_timer_mask;
  logic topoff_timer_mask;
  // charger mask three
  logic battery_low_for_otg_mask;
  logic thermistor_cold_mask;
  logic thermistor_cool_mask;
  logic thermistor_warm_mask;
  logic thermistor_hot_mask;
  // fault mask zero
  logic battery_current_reg_mask;
  logic input_bus_overvoltage_mask;
  logic battery_overvoltage_mask;
  logic input_overcurrent_mask;
  logic battery_overcurrent_mask;
  logic converter_overcurrent_mask;
  logic second_input_overvoltage_mask;
  logic first_input_overvoltage_mask;
  // fault mask one
  logic system_short_mask;
  logic system_overvoltage_mask;
  logic otg_output_overvoltage_mask;
  logic otg_output_undervoltage_mask;
  logic thermal_shutdown_mask;

  // field taps of charger mask two, a one blocks that event only
  assign dataline_detect_done_mask = mask_val[0][cem_pkg::DATALINE_DETECT_DONE_BIT];
  assign conv_done_mask = mask_val[0][cem_pkg::CONV_DONE_BIT];
  assign min_system_reg_mask = mask_val[0][cem_pkg::MIN_SYSTEM_REG_BIT];
  assign fast_charge_timer_mask = mask_val[0][cem_pkg::FAST_CHARGE_TIMER_BIT];
  assign trickle_timer_mask = mask_val[0][cem_pkg::TRICKLE_TIMER_BIT];
  assign precharge_timer_mask = mask_val[0][cem_pkg::PRECHARGE_TIMER_BIT];
  assign topoff_timer_mask = mask_val[0][cem_pkg::TOPOFF_TIMER_BIT];
  // charger mask three, the only byte the watchdog also clears
  assign battery_low_for_otg_mask = mask_val[1][cem_pkg::BATTERY_LOW_FOR_OTG_BIT];
  assign thermistor_cold_mask = mask_val[1][cem_pkg::THERMISTOR_COLD_BIT];
  assign thermistor_cool_mask = mask_val[1][cem_pkg::THERMISTOR_COOL_BIT];
  assign thermistor_warm_mask = mask_val[1][cem_pkg::THERMISTOR_WARM_BIT];
  assign thermistor_hot_mask = mask_val[1][cem_pkg::THERMISTOR_HOT_BIT];
  // fault mask zero
  assign battery_current_reg_mask = mask_val[2][cem_pkg::BATTERY_CURRENT_REG_BIT];
  assign input_bus_overvoltage_mask = mask_val[2][cem_pkg::INPUT_BUS_OVERVOLT_BIT];
  assign battery_overvoltage_mask = mask_val[2][cem_pkg::BATTERY_OVERVOLT_BIT];
  assign input_overcurrent_mask = mask_val[2][cem_pkg::INPUT_OVERCURRENT_BIT];
  assign battery_overcurrent_mask = mask_val[2][cem_pkg::BATTERY_OVERCURRENT_BIT];
  assign converter_overcurrent_mask = mask_val[2][cem_pkg::CONVERTER_OVERCURR_BIT];
  assign second_input_overvoltage_mask = mask_val[2][cem_pkg::SECOND_INPUT_OVP_BIT];
  assign first_input_overvoltage_mask = mask_val[2][cem_pkg::FIRST_INPUT_OVP_BIT];
  // fault mask one, bit 3 is storage only and gates nothing
  assign system_short_mask = mask_val[3][cem_pkg::SYSTEM_SHORT_BIT];
  assign system_overvoltage_mask = mask_val[3][cem_pkg::SYSTEM_OVERVOLT_BIT];
  assign otg_output_overvoltage_mask = mask_val[3][cem_pkg::OTG_OUTPUT_OVERVOLT_BIT];
  assign otg_output_undervoltage_mask = mask_val[3][cem_pkg::OTG_OUTPUT_UNDERVOLT_BIT];
  assign thermal_shutdown_mask = mask_val[3][cem_pkg::THERMAL_SHUTDOWN_BIT];

  // gate rows, reserved positions carry no event whatever the pins say
  assign passed[0] = events[0] & {1'b0, ~dataline_detect_done_mask, ~conv_done_mask,
                                  ~min_system_reg_mask, ~fast_charge_timer_mask,
                                  ~trickle_timer_mask, ~precharge_timer_mask,
                                  ~topoff_timer_mask};
  assign passed[1] = events[1] & {3'b000, ~battery_low_for_otg_mask, ~thermistor_cold_mask,
                                  ~thermistor_cool_mask, ~thermistor_warm_mask,
                                  ~thermistor_hot_mask};
  assign passed[2] = events[2] & ~{battery_current_reg_mask, input_bus_overvoltage_mask,
                                   battery_overvoltage_mask, input_overcurrent_mask,
                                   battery_overcurrent_mask, converter_overcurrent_mask,
                                   second_input_overvoltage_mask,
                                   first_input_overvoltage_mask};
  assign passed[3] = events[3] & {~system_short_mask, ~system_overvoltage_mask,
                                  ~otg_output_overvoltage_mask, ~otg_output_undervoltage_mask,
                                  1'b0, ~thermal_shutdown_mask, 2'b00};

  // read mux, unmapped offsets answer with zero
  assign rd_data    = (|rd_sel) ? (rd_terms[0] | rd_terms[1] | rd_terms[2] | rd_terms[3])
                                : cem_pkg::UNMAPPED_RDATA;
  assign any_passed = |passed;

  // read answer lands one cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= i_reg_rd ? rd_data : rdata_r;
      rvalid_r <= i_reg_rd;
    end
  end

  // interrupt pulse, one cycle per cycle with an unmasked event
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_r <= 1'b0;
    end else begin
      int_r <= any_passed;
    end
  end

  // flags see raw events so masking never hides a status change
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= {i_fault_events_one, i_fault_events_zero,
                  i_charger_events_three, i_charger_events_two};
    end
  end

  assign o_reg_rdata           = rdata_r;
  assign o_reg_rvalid          = rvalid_r;
  assign o_int_pulse           = int_r;
  assign o_charger_flags_two   = flags_r[0];
  assign o_charger_flags_three = flags_r[1];
  assign o_fault_flags_zero    = flags_r[2];
  assign o_fault_flags_one     = flags_r[3];
endmodule : cem_interrupt_masks
`default_nettype wire

// ### testbench/cem_masks_properties.sv
// checker for the charger event mask bank
// assumes binding to the top module and one-cycle strobes
`default_nettype none
module cem_masks_properties (
  // clock and reset
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  // register port
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] o_reg_rdata,
  // clears and converter mode
  input wire logic       i_reg_reset_cmd,
  input wire logic       i_watchdog_expire,
  input wire logic       i_conv_single_shot,
  // events and responses
  input wire logic [7:0] i_charger_events_two,
  input wire logic [7:0] i_charger_events_three,
  input wire logic [7:0] i_fault_events_zero,
  input wire logic [7:0] i_fault_events_one,
  input wire logic [7:0] o_fault_flags_zero,
  input wire logic       o_int_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // events outside the first charger register
  wire logic other_ev = |{i_charger_events_three, i_fault_events_zero, i_fault_events_one};
  sequence s_rd(logic [7:0] a);
    i_reg_rd && !i_reg_wr && i_reg_addr == a;
  endsequence
  a_idle_no_int:
    assert property (!other_ev && !(|i_charger_events_two) |=> !o_int_pulse)
    else $error("interrupt without event");
  a_flags_raw:
    assert property (1'b1 |=> o_fault_flags_zero == $past(i_fault_events_zero))
    else $error("flags differ from events");
  a_conv_mode:
    assert property (i_charger_events_two == 8'h20 && !other_ev && !i_conv_single_shot
      |=> !o_int_pulse) else $error("conversion interrupt outside single shot");
  a_cmd_clears:
    assert property (i_reg_reset_cmd ##1 s_rd(8'h2C) |=> o_reg_rdata == 8'h00)
    else $error("mask survives reset command");
  a_wd_clears:
    assert property (i_watchdog_expire ##1 s_rd(8'h2B) |=> o_reg_rdata == 8'h00)
    else $error("mask survives watchdog");
  a_cmd_unmasks:
    assert property (i_reg_reset_cmd ##1 (|i_fault_events_zero) |=> o_int_pulse)
    else $error("fault not passed after clear");
  a_tshut_unmask:
    assert property (i_reg_reset_cmd ##1 i_fault_events_one[2] |=> o_int_pulse)
    else $error("thermal fault not passed after clear");
  a_wd_unmasks:
    assert property (i_watchdog_expire ##1 i_charger_events_three[0] |=> o_int_pulse)
    else $error("zone crossing not passed after watchdog");
endmodule : cem_masks_properties
bind cem_interrupt_masks cem_masks_properties u_props (.i_sys_clk, .i_rst_n, .i_reg_wr,
  .i_reg_rd, .i_reg_reset_cmd, .i_watchdog_expire, .i_conv_single_shot, .o_int_pulse,
  .i_reg_addr, .o_reg_rdata, .i_charger_events_two, .i_charger_events_three,
  .i_fault_events_zero, .i_fault_events_one, .o_fault_flags_zero);
`default_nettype wire

// ### testbench/cem_host_model.sv
// host side: counts interrupt pulses
// assumes one-cycle pulses on the system clock
`default_nettype none
module cem_host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_int_pulse,
  output var int    o_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // every high cycle is one event to service
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_count <= 0;
    else if (i_int_pulse === 1'b1) o_count <= o_count + 1;
  end
endmodule : cem_host_model
`default_nettype wire

// ### testbench/cem_interrupt_masks_bench.sv
// bench for the charger event mask bank
// assumes results one cycle after each strobe
`default_nettype none
module cem_interrupt_masks_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ACC = 32'hFCFF1F7F, EVT = 32'hF4FF1F7F;
  logic       clk = 0, rst_n = 0, wr = 0, rd = 0, cmd = 0, wd = 0, ss = 1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, e2 = 8'h00, e3 = 8'h00, f0 = 8'h00, f1 = 8'h00;
  wire logic [31:0] flags;
  wire logic [7:0]  rdata;
  wire logic        rvalid, intp;
  int               num_errors = 0, checks_done = 0, ints_exp = 0, ints_seen;
  cem_interrupt_masks DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_reg_reset_cmd(cmd), .i_watchdog_expire(wd), .i_conv_single_shot(ss),
    .i_charger_events_two(e2), .i_charger_events_three(e3), .i_fault_events_zero(f0),
    .i_fault_events_one(f1), .o_charger_flags_two(flags[7:0]),
    .o_charger_flags_three(flags[15:8]), .o_fault_flags_zero(flags[23:16]),
    .o_fault_flags_one(flags[31:24]), .o_int_pulse(intp));
  cem_host_model HOST (.i_sys_clk(clk), .i_rst_n(rst_n), .i_int_pulse(intp), .o_count(ints_seen));
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // each bus task also drops any pending clear pulse
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {cmd, wd, wr, addr, wdata} <= {3'b001, a, d};
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) {cmd, wd, rd, addr} <= {3'b001, a};
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) check({rvalid, rdata}, {1'b1, exp});
  endtask : rd_reg
  task automatic pulse(input logic c, input logic w);
    @(posedge clk) {cmd, wd} <= {c, w};
  endtask : pulse
  // flags must copy the raw event whatever the masks say
  task automatic event_cyc(input logic [31:0] e, input logic exp);
    @(posedge clk) {cmd, wd, f1, f0, e3, e2} <= {2'b00, e};
    @(posedge clk) {f1, f0, e3, e2} <= 32'h0;
    @(negedge clk) check({intp, flags}, {exp, e});
    ints_exp += exp;
  endtask : event_cyc
  task automatic t_regs;
    for (int r = 0; r < 4; r++) rd_reg(8'h2A + 8'(r), 8'h00);
    rd_reg(8'h40, 8'h00);
    for (int r = 0; r < 4; r++) begin
      wr_reg(8'h2A + 8'(r), 8'hFF);
      rd_reg(8'h2A + 8'(r), ACC[r*8+:8]);
    end
    $display("regs test done");
  endtask : t_regs
  task automatic t_wd;
    pulse(1'b0, 1'b1);
    rd_reg(8'h2B, 8'h00);
    rd_reg(8'h2A, 8'h7F);
    pulse(1'b0, 1'b1);
    event_cyc(32'h100, 1'b1);
    event_cyc(32'h10000, 1'b0);
    $display("watchdog test done");
  endtask : t_wd
  task automatic t_masks;
    pulse(1'b1, 1'b0);
    rd_reg(8'h2C, 8'h00);
    for (int i = 0; i < 32; i++) begin
      pulse(1'b1, 1'b0);
      event_cyc(32'h1 << i, EVT[i]);
    end
    for (int r = 0; r < 4; r++) wr_reg(8'h2A + 8'(r), 8'hFF);
    for (int i = 0; i < 32; i++) event_cyc(32'h1 << i, 1'b0);
    $display("mask test done");
  endtask : t_masks
  // conversion done only counts in single-shot mode
  task automatic t_conv;
    pulse(1'b1, 1'b0);
    @(posedge clk) {cmd, ss} <= 2'b00;
    event_cyc(32'h20, 1'b0);
    @(posedge clk) ss <= 1'b1;
    event_cyc(32'h20, 1'b1);
    $display("conversion test done");
  endtask : t_conv
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_wd;
    t_masks;
    t_conv;
    @(negedge clk) check(ints_seen, ints_exp);
    final_report;
  end
  // run needs well under a thousand cycles
  initial begin
    #200000;
    num_errors++;
    final_report;
  end
endmodule : cem_interrupt_masks_bench
`default_nettype wire
